// ===== hdl/slcd_clkdiv.sv
/*
  Frame operating clock divider: one-cycle enable per operating clock.
  Assumes the subclock arrives as a one-cycle pulse synchronous to clk.
*/
`timescale 1ns/1ps
module slcd_clkdiv
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // to control core
  slcd_tick_if.div tk
);

  logic [7:0] preCnt_ff;
  logic [7:0] nxt_preCnt;
  logic [1:0] subCnt_ff;
  logic [1:0] nxt_subCnt;
  logic tick_ff;
  logic nxt_tick;
  logic [7:0] sysMask;
  logic sysTick;
  logic subSel;

  // mask of low bits that must all be one for system clock /2^(n+1)
  assign sysMask = 8'hFF >> (3'h7 - tk.clkSel[2:0]);
  assign sysTick = (preCnt_ff & sysMask) == sysMask;

  always_comb
  begin
    nxt_preCnt = tk.run ? preCnt_ff + 8'h01 : 8'h00;
    nxt_subCnt = subCnt_ff;
    if (!tk.run)
      nxt_subCnt = 2'h0;
    else if (tk.subTick)
      nxt_subCnt = subCnt_ff + 2'h1;
    if (tk.clkSel[1])
      subSel = tk.subTick & (&subCnt_ff);
    else if (tk.clkSel[0])
      subSel = tk.subTick & subCnt_ff[0];
    else
      subSel = tk.subTick;
    nxt_tick = tk.run & (tk.clkSel[3] ? sysTick : subSel);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      preCnt_ff <= 8'h00;
      subCnt_ff <= 2'h0;
      tick_ff <= 1'b0;
    end
    else
    begin
      preCnt_ff <= nxt_preCnt;
      subCnt_ff <= nxt_subCnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tk.opTick = tick_ff;
  assign tk.preCnt = preCnt_ff[4:0];

  property p_sys_div2_spacing;
    @(posedge clk) disable iff (!rstn)
    (tk.run && tk.clkSel == 4'h8)
      ##1 (tk.run && tk.clkSel == 4'h8 && tick_ff)
      ##1 (tk.run && tk.clkSel == 4'h8) |-> !tick_ff ##1 tick_ff;
  endproperty
  a_sys_div2_spacing: assert property (p_sys_div2_spacing)
    else $error("system clock /2 tick spacing wrong");

endmodule : slcd_clkdiv

// ===== hdl/slcd_ctrl.sv
/*
  Segment LCD drive control: duty and common selection, frame timing,
  display enable, blanking, power switch, A/B waveform, charge pulse.
  Assumes a plain register strobe port and a display RAM that answers
  ramSegBits combinationally for the phase on ramPhase_ff.
*/
`timescale 1ns/1ps
`include "slcd_cfg.svh"
module slcd_ctrl
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata_ff,
  // subclock enable pulse
  input wire logic subClkTick,
  // display RAM
  output logic [1:0] ramPhase_ff,
  input wire logic [31:0] ramSegBits,
  // panel drive
  output logic [7:0] comDrive_ff,
  output logic [31:0] segDrive_ff,
  output logic drivePolarity_ff,
  // supply control
  output logic drivePowerEn_ff,
  output logic chargePulse_ff
);

  slcd_tick_if tk ();

  // register state
  logic [7:0] portCtl_ff;
  logic [7:0] nxt_portCtl;
  logic [7:0] ctl_ff;
  logic [7:0] nxt_ctl;
  logic [7:0] ctl2_ff;
  logic [7:0] nxt_ctl2;
  logic [7:0] nxt_rdata;

  // frame state
  logic [1:0] phase_ff;
  logic [1:0] nxt_phase;
  logic pol_ff;
  logic nxt_pol;
  logic lastPhase;

  // output next values
  logic [3:0] comUsed;
  logic [3:0] comSel;
  logic [7:0] nxt_com;
  logic [31:0] nxt_seg;
  logic nxt_pulse;
  logic pulseRaw;

  // decoded fields
  slcd_pkg::slcd_duty_t duty;
  logic commonExpand;
  logic drivePowerSwitch;
  logic displayActivate;
  logic showRamData;
  logic waveformType;
  logic [3:0] frameClkSel;
  logic [3:0] pulseDutySel;

  assign duty = slcd_pkg::slcd_duty_t'(
    portCtl_ff[`SLCD_DUTY_HI:`SLCD_DUTY_LO]);
  assign commonExpand = portCtl_ff[`SLCD_EXPAND_BIT];
  assign drivePowerSwitch = ctl_ff[`SLCD_POWER_BIT];
  assign displayActivate = ctl_ff[`SLCD_RUN_BIT];
  assign showRamData = ctl_ff[`SLCD_SHOW_BIT];
  assign frameClkSel = ctl_ff[`SLCD_CKS_HI:0];
  assign waveformType = ctl2_ff[`SLCD_WAVE_BIT];
  assign pulseDutySel = ctl2_ff[`SLCD_CDS_HI:0];

  assign tk.run = displayActivate;
  assign tk.clkSel = frameClkSel;
  assign tk.subTick = subClkTick;

  slcd_clkdiv u_div
  (
    .clk(clk),
    .rstn(rstn),
    .tk(tk)
  );

  // register port: writes store, reads answer next cycle only
  always_comb
  begin
    nxt_portCtl = portCtl_ff;
    nxt_ctl = ctl_ff;
    nxt_ctl2 = ctl2_ff;
    nxt_rdata = `SLCD_READ_NONE;
    if (regWr)
    begin
      case (regAddr)
        `SLCD_ADDR_PORTCTL: nxt_portCtl = regWdata;
        `SLCD_ADDR_CTL: nxt_ctl = regWdata & `SLCD_CTL_WMASK;
        `SLCD_ADDR_CTL2: nxt_ctl2 = regWdata & `SLCD_CTL2_WMASK;
        default: nxt_rdata = `SLCD_READ_NONE;
      endcase
    end
    if (regRd)
    begin
      case (regAddr)
        `SLCD_ADDR_PORTCTL: nxt_rdata = portCtl_ff;
        `SLCD_ADDR_CTL: nxt_rdata = ctl_ff | `SLCD_CTL_FIXED1;
        `SLCD_ADDR_CTL2: nxt_rdata = ctl2_ff | `SLCD_CTL2_FIXED1;
        default: nxt_rdata = `SLCD_READ_NONE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      portCtl_ff <= `SLCD_PORTCTL_RESET;
      ctl_ff <= `SLCD_CTL_RESET;
      ctl2_ff <= `SLCD_CTL2_RESET;
      regRdata_ff <= `SLCD_READ_NONE;
    end
    else
    begin
      portCtl_ff <= nxt_portCtl;
      ctl_ff <= nxt_ctl;
      ctl2_ff <= nxt_ctl2;
      regRdata_ff <= nxt_rdata;
    end
  end

  // frame timing; the duty code equals the last phase index.
  // >= wrap so a duty change mid-frame never strands the counter
  assign lastPhase = phase_ff >= portCtl_ff[`SLCD_DUTY_HI:`SLCD_DUTY_LO];

  always_comb
  begin
    nxt_phase = phase_ff;
    nxt_pol = pol_ff;
    if (!displayActivate)
    begin
      nxt_phase = 2'h0;
      nxt_pol = 1'b0;
    end
    else if (tk.opTick)
    begin
      nxt_phase = lastPhase ? 2'h0 : phase_ff + 2'h1;
      // A flips every phase, B once per frame; both stay DC free
      if (!waveformType || lastPhase)
        nxt_pol = !pol_ff;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase_ff <= 2'h0;
      pol_ff <= 1'b0;
    end
    else
    begin
      phase_ff <= nxt_phase;
      pol_ff <= nxt_pol;
    end
  end

  // common usage and selection per duty
  always_comb
  begin
    comUsed = 4'h0;
    comSel = 4'h0;
    case (duty)
      slcd_pkg::DUTY_STATIC:
      begin
        comUsed = commonExpand ? 4'hF : 4'h1;
        comSel = comUsed;
      end
      slcd_pkg::DUTY_HALF:
      begin
        comUsed = commonExpand ? 4'hF : 4'h3;
        if (commonExpand)
          comSel = (phase_ff == 2'h0) ? 4'h3 : 4'hC;
        else
          comSel = (phase_ff == 2'h0) ? 4'h1 : 4'h2;
      end
      slcd_pkg::DUTY_THIRD:
      begin
        comUsed = commonExpand ? 4'hF : 4'h7;
        comSel = (4'h1 << phase_ff) & 4'h7;
      end
      slcd_pkg::DUTY_QUARTER:
      begin
        comUsed = 4'hF;
        comSel = 4'h1 << phase_ff;
      end
      default:
      begin
        comUsed = 4'h0;
        comSel = 4'h0;
      end
    endcase
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_com
      assign nxt_com[2*gi+1:2*gi] =
        (!displayActivate || !comUsed[gi]) ? slcd_pkg::LVL_IDLE :
        comSel[gi] ? slcd_pkg::LVL_SEL : slcd_pkg::LVL_NONSEL;
    end
  endgenerate

  // charge pulse from the prescaler low bits
  always_comb
  begin
    if (pulseDutySel[3])
      pulseRaw = pulseDutySel[2] ? (tk.preCnt == 5'h00)
        : (tk.preCnt[3:0] == 4'h0);
    else if (pulseDutySel == 4'h0)
      pulseRaw = 1'b1;
    else if (pulseDutySel == 4'h7)
      pulseRaw = 1'b0;
    else
      pulseRaw = tk.preCnt[2:0] < pulseDutySel[2:0];
    nxt_pulse = pulseRaw & displayActivate & drivePowerSwitch;
    // blank data drives all segments off
    nxt_seg = (displayActivate && showRamData) ? ramSegBits
      : 32'h0000_0000;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      comDrive_ff <= 8'h00;
      segDrive_ff <= 32'h0000_0000;
      drivePolarity_ff <= 1'b0;
      drivePowerEn_ff <= 1'b0;
      chargePulse_ff <= 1'b0;
      ramPhase_ff <= 2'h0;
    end
    else
    begin
      comDrive_ff <= nxt_com;
      segDrive_ff <= nxt_seg;
      drivePolarity_ff <= nxt_pol;
      drivePowerEn_ff <= drivePowerSwitch;
      chargePulse_ff <= nxt_pulse;
      ramPhase_ff <= nxt_phase;
    end
  end

  property p_quarter_all;
    @(posedge clk) disable iff (!rstn)
    (displayActivate && duty == slcd_pkg::DUTY_QUARTER)
      |=> (comDrive_ff[1:0] != 2'h0 && comDrive_ff[3:2] != 2'h0
        && comDrive_ff[5:4] != 2'h0 && comDrive_ff[7:6] != 2'h0);
  endproperty
  a_quarter_all: assert property (p_quarter_all)
    else $error("quarter duty left a common idle");

  property p_static_copy;
    @(posedge clk) disable iff (!rstn)
    (displayActivate && duty == slcd_pkg::DUTY_STATIC)
      |=> (commonExpand ? comDrive_ff[7:2] == {3{comDrive_ff[1:0]}}
        : comDrive_ff[7:2] == 6'h00) && comDrive_ff[1:0] == 2'h2;
  endproperty
  a_static_copy: assert property (p_static_copy)
    else $error("static duty commons wrong");

  property p_half_pairs;
    @(posedge clk) disable iff (!rstn)
    (displayActivate && duty == slcd_pkg::DUTY_HALF && commonExpand)
      |=> comDrive_ff[3:2] == comDrive_ff[1:0]
        && comDrive_ff[7:6] == comDrive_ff[5:4]
        && comDrive_ff[1:0] != comDrive_ff[5:4];
  endproperty
  a_half_pairs: assert property (p_half_pairs)
    else $error("half duty expanded pairing wrong");

  property p_third_nonsel;
    @(posedge clk) disable iff (!rstn)
    (displayActivate && duty == slcd_pkg::DUTY_THIRD && commonExpand)
      |=> comDrive_ff[7:6] == 2'h1;
  endproperty
  a_third_nonsel: assert property (p_third_nonsel)
    else $error("third duty common four not non-selected");

  property p_blank;
    @(posedge clk) disable iff (!rstn)
    !showRamData |=> segDrive_ff == 32'h0000_0000;
  endproperty
  a_blank: assert property (p_blank)
    else $error("segments driven while blanked");

  property p_halt;
    @(posedge clk) disable iff (!rstn)
    !displayActivate ##1 !displayActivate
      |-> comDrive_ff == 8'h00 && !chargePulse_ff && phase_ff == 2'h0;
  endproperty
  a_halt: assert property (p_halt)
    else $error("driver active while halted");

  property p_power;
    @(posedge clk) disable iff (!rstn)
    $changed(drivePowerSwitch)
      |=> drivePowerEn_ff == $past(drivePowerSwitch);
  endproperty
  a_power: assert property (p_power)
    else $error("supply enable did not follow switch");

  property p_wave_b_hold;
    @(posedge clk) disable iff (!rstn)
    (displayActivate && waveformType && tk.opTick && !lastPhase)
      |=> drivePolarity_ff == pol_ff && $stable(pol_ff);
  endproperty
  a_wave_b_hold: assert property (p_wave_b_hold)
    else $error("B waveform flipped inside frame");

  property p_pulse_zero;
    @(posedge clk) disable iff (!rstn)
    (pulseDutySel == 4'h7) |=> !chargePulse_ff;
  endproperty
  a_pulse_zero: assert property (p_pulse_zero)
    else $error("zero duty charge pulse seen");

  property p_port_read;
    @(posedge clk) disable iff (!rstn)
    (regRd && regAddr == `SLCD_ADDR_PORTCTL)
      |=> regRdata_ff == $past(portCtl_ff);
  endproperty
  a_port_read: assert property (p_port_read)
    else $error("port control readback wrong");

  property p_frame_wrap;
    @(posedge clk) disable iff (!rstn)
    (displayActivate && tk.opTick && lastPhase) |=> phase_ff == 2'h0;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap)
    else $error("phase did not wrap at frame end");

endmodule : slcd_ctrl

// ===== inc/slcd_cfg.svh
/*
  Register map, field positions and reset values of the segment LCD
  drive control. Assumes byte-wide registers on a plain strobe port.
*/
`ifndef SLCD_CFG_SVH
`define SLCD_CFG_SVH

`define SLCD_ADDR_PORTCTL 8'hC0
`define SLCD_ADDR_CTL 8'hC1
`define SLCD_ADDR_CTL2 8'hC2

`define SLCD_PORTCTL_RESET 8'h00
`define SLCD_CTL_RESET 8'h00
`define SLCD_CTL_FIXED1 8'h80
`define SLCD_CTL_WMASK 8'h7F
`define SLCD_CTL2_RESET 8'h00
`define SLCD_CTL2_FIXED1 8'h60
`define SLCD_CTL2_WMASK 8'h9F
`define SLCD_READ_NONE 8'h00

`define SLCD_DUTY_HI 7
`define SLCD_DUTY_LO 6
`define SLCD_EXPAND_BIT 5
`define SLCD_POWER_BIT 6
`define SLCD_RUN_BIT 5
`define SLCD_SHOW_BIT 4
`define SLCD_CKS_HI 3
`define SLCD_WAVE_BIT 7
`define SLCD_CDS_HI 3

`endif

// ===== inc/slcd_pkg.sv
/*
  Types shared by the segment LCD drive control.
  Assumes the constants header is compiled alongside.
*/
package slcd_pkg;

  typedef enum logic [1:0] {
    DUTY_STATIC = 2'b00,
    DUTY_HALF = 2'b01,
    DUTY_THIRD = 2'b10,
    DUTY_QUARTER = 2'b11
  } slcd_duty_t;

  typedef enum logic [1:0] {
    LVL_IDLE = 2'b00,
    LVL_NONSEL = 2'b01,
    LVL_SEL = 2'b10
  } slcd_level_t;

endpackage : slcd_pkg

// ===== inc/slcd_tick_if.sv
/*
  Carrier between the control core and its frame clock divider.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface slcd_tick_if;
  logic run;
  logic [3:0] clkSel;
  logic subTick;
  logic opTick;
  logic [4:0] preCnt;

  modport ctrl (output run, output clkSel, output subTick,
    input opTick, input preCnt);
  modport div (input run, input clkSel, input subTick,
    output opTick, output preCnt);
endinterface : slcd_tick_if

// ===== testbench/segment_lcd_drive_control_tb_top.sv
/*
  Self-checking bench: register tasks on the strobe port, then duty,
  frame clock, blanking, waveform, power and charge pulse checks.
  Assumes the panel model supplies RAM data and the subclock pulse.
*/
`timescale 1ns/1ps
module segment_lcd_drive_control_tb_top;
  localparam int SUBP = 4;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata_ff;
  logic subClkTick;
  logic [1:0] ramPhase_ff;
  logic [31:0] ramSegBits;
  logic [7:0] comDrive_ff;
  logic [31:0] segDrive_ff;
  logic drivePolarity_ff;
  logic drivePowerEn_ff;
  logic chargePulse_ff;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  slcd_ctrl uut (.clk(clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata_ff(regRdata_ff), .subClkTick(subClkTick),
    .ramPhase_ff(ramPhase_ff), .ramSegBits(ramSegBits),
    .comDrive_ff(comDrive_ff), .segDrive_ff(segDrive_ff),
    .drivePolarity_ff(drivePolarity_ff),
    .drivePowerEn_ff(drivePowerEn_ff), .chargePulse_ff(chargePulse_ff));

  slcd_panel_model #(.SUB_PERIOD(SUBP)) panel (.clk(clk), .rstn(rstn),
    .ramPhase_ff(ramPhase_ff), .ramSegBits(ramSegBits),
    .subClkTick(subClkTick));

  task automatic end_sim;
  begin
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask : end_sim

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
  begin
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
  begin
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk({24'h0, regRdata_ff}, {24'h0, e});
  end
  endtask : rd

  task automatic run_duty(input logic [1:0] d, input logic c);
    logic [3:0] used;
    logic [1:0] mx;
    int bad;
  begin
    wr(8'hC0, {d, c, 5'h00});
    wr(8'hC1, 8'h28);
    used = 4'h0;
    mx = 2'h0;
    bad = 0;
    // commons follow the activate bit one cycle late
    @(negedge clk);
    repeat (64)
    begin
      @(negedge clk);
      for (int i = 0; i < 4; i++)
        if (comDrive_ff[2*i +: 2] !== 2'b00)
          used[i] = 1'b1;
      if (ramPhase_ff > mx)
        mx = ramPhase_ff;
      if (c && d == 2'b00 && comDrive_ff !== {4{comDrive_ff[1:0]}})
        bad++;
      if (c && d == 2'b01 && (comDrive_ff[3:2] !== comDrive_ff[1:0]
          || comDrive_ff[7:6] !== comDrive_ff[5:4]))
        bad++;
      if (c && d == 2'b10 && comDrive_ff[7:6] !== 2'b01)
        bad++;
    end
    chk(used, (c || d == 2'b11) ? 4'hF : (4'h1 << (d + 1)) - 4'h1);
    chk(mx, d);
    chk(bad, 0);
    wr(8'hC1, 8'h00);
    repeat (4) @(negedge clk);
    chk({comDrive_ff, ramPhase_ff, drivePolarity_ff}, 0);
  end
  endtask : run_duty

  task automatic frame_gap(output int n);
    logic [1:0] p;
  begin
    n = 0;
    // first gap is partial after a rate change; keep the second
    @(negedge clk);
    for (int k = 0; k < 2; k++)
    begin
      p = ramPhase_ff;
      n = 0;
      while (ramPhase_ff === p && n < 2000)
      begin
        @(negedge clk);
        n++;
      end
    end
  end
  endtask : frame_gap

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  initial
  begin
    int n;
    int bad;
    int tog;
    int wraps;
    logic prevPol;
    logic [1:0] prev;
    logic [3:0] cds [12];
    cds = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
      4'h8, 4'hB, 4'hC, 4'hF};
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rd(8'hC0, 8'h00);
    rd(8'hC1, 8'h80);
    rd(8'hC2, 8'h60);
    rd(8'hC3, 8'h00);
    wr(8'hC0, 8'hFF);
    rd(8'hC0, 8'hFF);
    wr(8'hC2, 8'hFF);
    rd(8'hC2, 8'hFF);
    wr(8'hC2, 8'h00);
    rd(8'hC2, 8'h60);
    for (int d = 0; d < 4; d++)
      for (int c = 0; c < 2; c++)
        run_duty(d[1:0], c[0]);
    // quarter duty: ramPhase steps once per operating clock
    wr(8'hC0, 8'hC0);
    for (int i = 0; i < 16; i++)
    begin
      wr(8'hC1, 8'h20 | i[7:0]);
      frame_gap(n);
      chk(n, i[3] ? 2 << i[2:0] : SUBP * (i[1] ? 4 : i[0] ? 2 : 1));
    end
    wr(8'hC1, 8'h38);
    bad = 0;
    repeat (4) @(negedge clk);
    prev = ramPhase_ff;
    repeat (64)
    begin
      @(negedge clk);
      if (segDrive_ff !== ({16{prev}} ^ 32'hA5C39F06))
        bad++;
      prev = ramPhase_ff;
    end
    chk(bad, 0);
    wr(8'hC1, 8'h28);
    repeat (4) @(negedge clk);
    chk(segDrive_ff, 0);
    // A flips on every phase step, B only on the wrap to phase 0
    for (int w = 0; w < 2; w++)
    begin
      wr(8'hC2, w ? 8'h80 : 8'h00);
      tog = 0;
      wraps = 0;
      bad = 0;
      @(negedge clk);
      prev = ramPhase_ff;
      prevPol = drivePolarity_ff;
      repeat (128)
      begin
        @(negedge clk);
        tog += (ramPhase_ff !== prev);
        wraps += (ramPhase_ff !== prev && ramPhase_ff == 2'h0);
        if ((drivePolarity_ff !== prevPol) !== (ramPhase_ff !== prev
            && (w == 0 || ramPhase_ff == 2'h0)))
          bad++;
        prev = ramPhase_ff;
        prevPol = drivePolarity_ff;
      end
      chk(bad, 0);
      chk(tog, 64);
      chk(wraps, 16);
    end
    wr(8'hC1, 8'h68);
    repeat (2) @(negedge clk);
    chk(drivePowerEn_ff, 1'b1);
    // 64 cycles hold whole periods of every pulse rate
    for (int j = 0; j < 12; j++)
    begin
      wr(8'hC2, {4'h0, cds[j]});
      @(negedge clk);
      n = 0;
      repeat (64)
      begin
        @(negedge clk);
        n += chargePulse_ff;
      end
      chk(n, cds[j] == 4'h0 ? 64 : cds[j] < 4'h7 ? 8 * cds[j] :
        cds[j] == 4'h7 ? 0 : cds[j][2] ? 2 : 4);
    end
    wr(8'hC1, 8'h28);
    repeat (2) @(negedge clk);
    chk({drivePowerEn_ff, chargePulse_ff}, 2'b00);
    end_sim();
  end
endmodule : segment_lcd_drive_control_tb_top

// ===== testbench/slcd_panel_model.sv
/*
  Far-side model: display RAM answering segment bits for the phase
  asked, plus a subclock enable pulse every SUB_PERIOD clocks.
  Assumes one clock shared with the drive control.
*/
`timescale 1ns/1ps
module slcd_panel_model
#(
  parameter int SUB_PERIOD = 4
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // display RAM
  input wire logic [1:0] ramPhase_ff,
  output logic [31:0] ramSegBits,
  // subclock enable
  output logic subClkTick
);
  int subCnt;

  // distinct pattern per phase so a stale phase shows up
  assign ramSegBits = {16{ramPhase_ff}} ^ 32'hA5C39F06;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      subCnt <= 0;
      subClkTick <= 1'b0;
    end
    else
    begin
      subCnt <= (subCnt == SUB_PERIOD - 1) ? 0 : subCnt + 1;
      subClkTick <= (subCnt == SUB_PERIOD - 1);
    end
  end
endmodule : slcd_panel_model
